// >>> nvmc_regs.vh
// Register offsets, field positions, commands and timing counts for the
// nonvolatile memory controller. Assumes an 8-bit peripheral register port.
// Function
// RULE1: One interrupt source, vector offset 0x00, flag set when data array ready.
// RULE2: Interrupt request asserted while ready flag and enable are both one.
// RULE3: With no write in progress, controller sleeps together with the system.
// RULE4: A write in progress keeps array, controller and clock awake until done.
// RULE5: Ready interrupt wakes the device from idle sleep only.
// RULE6: Page buffer is cleared to erased state on wake from any sleep.
// RULE7: Command write accepted only within four instructions after the key write. Code also accepts debug port writes with no key.
// RULE8: Guarded command write outside the window completes but changes nothing.
// RULE9: Command field is bits 2:0, resets to zero, 0x0 is no operation.
// RULE10: 0x1 program, 0x2 erase, 0x3 erase-program page; target picks the array.
// RULE11: 0x4 clears the page buffer; 0x6 erases the whole data array.
// RULE12: 0x5 erases both arrays; data array kept when preserve fuse is one.
// RULE13: 0x7 fuse burn accepted only from the debug programming port.
// RULE14: With loader lock active, boot region reads and fetches return zero.
// RULE15: Loader lock writable only from boot region; cleared only by reset.
// RULE16: New loader lock takes effect after execution first leaves boot region.
// RULE17: Lock bit 0 set-only, blocks application region writes, reset clears.
// RULE18: Status bit 2 reads one when the last operation hit a write error.
// RULE19: Status bit 1 reads one while the data array executes a command.
// RULE20: Status bit 0 reads one while the code array executes a command.
// RULE21: Software should not enable ready interrupt early; disable it in handler.
// RULE22: Writing one clears flag bit 0; enabled interrupt requests continuously.
// RULE23: Data register low byte at base, high byte at base plus 0x01.
// RULE24: Port loads target and data, then burns fuse; reset needed to apply.
// RULE25: Target register holds address of the most recently updated location.
// RULE26: Page buffer all ones after reset, page write or erase, and buffer clear.
// RULE27: Ready flag set on the cycle the data array operation completes.
`ifndef NVMC_REGS_VH
`define NVMC_REGS_VH

`define NVMC_OFF_CMD      4'h0
`define NVMC_OFF_LOCK     4'h1
`define NVMC_OFF_STATUS   4'h2
`define NVMC_OFF_IRQEN    4'h3
`define NVMC_OFF_IRQFLAG  4'h4
`define NVMC_OFF_DATA_L   4'h6
`define NVMC_OFF_DATA_H   4'h7
`define NVMC_OFF_ADDR_L   4'h8
`define NVMC_OFF_ADDR_H   4'h9

`define NVMC_IRQ_VECTOR   8'h00

`define NVMC_LOCK_APP     0
`define NVMC_LOCK_BOOT    1
`define NVMC_ST_CODE      0
`define NVMC_ST_DATA      1
`define NVMC_ST_FAULT     2

`define NVMC_CMD_NONE     3'h0
`define NVMC_CMD_PROG     3'h1
`define NVMC_CMD_ERASE    3'h2
`define NVMC_CMD_ERPROG   3'h3
`define NVMC_CMD_WIPE     3'h4
`define NVMC_CMD_CHIP     3'h5
`define NVMC_CMD_DERASE   3'h6
`define NVMC_CMD_FUSE     3'h7

`define NVMC_KEY_WINDOW   3'h4

`define NVMC_SLEEP_IDLE   2'h1

// Operation durations in cycles of the 250 MHz clock
`define NVMC_T_WIPE       16'h0007
`define NVMC_T_PAGE       16'h0100
`define NVMC_T_ARRAY      16'h0400
`define NVMC_T_FUSE       16'h0040

`define NVMC_BUF_DEPTH    64
`define NVMC_BUF_AW       6

`endif

// >>> nvmc_ctrl.v
// Nonvolatile memory controller: command sequencer, page buffer, locks,
// status and data-ready interrupt. Assumes the core signals instruction
// retirement, key writes, sleep entry/wake, and region of the current fetch.
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_regs.vh"

module nvmc_ctrl #(
    parameter [15:0] DATA_BASE  = 16'h1400,  // Start of data array window
    parameter [15:0] DATA_END   = 16'h14ff,  // End of data array window
    parameter [15:0] BOOT_END   = 16'h81ff,  // Last address of boot region
    parameter [15:0] APP_END    = 16'h9fff,  // Last address of application region
    parameter [15:0] CODE_BASE  = 16'h8000   // Start of code array window
) (
    input  wire        mclk,          // Clock
    input  wire        rst,           // Asynchronous reset, active high
    input  wire [3:0]  reg_addr,      // Register offset
    input  wire        reg_wr,        // Register write strobe
    input  wire        reg_rd,        // Register read strobe
    input  wire [7:0]  reg_wdata,     // Register write data
    output reg  [7:0]  reg_rdata,     // Register read data
    input  wire        dbg_access,    // Access comes from debug programming port
    input  wire        key_written,   // Self-program key written this cycle
    input  wire        instr_retire,  // One instruction retired this cycle
    input  wire        exec_in_boot,  // Current fetch lies in boot region
    input  wire        buf_wr,        // Page buffer store
    input  wire [15:0] buf_addr,      // Page buffer store address
    input  wire [7:0]  buf_wdata,     // Page buffer store data
    input  wire        mem_rd,        // Array read or fetch
    input  wire [15:0] mem_addr,      // Array read address
    input  wire [7:0]  mem_rdata_raw, // Raw array read data
    output reg  [7:0]  mem_rdata,     // Array read data after lock masking
    input  wire        keep_data_fuse,// Preserve data array on whole erase
    input  wire        sleep_enter,   // System enters sleep this cycle
    input  wire [1:0]  sleep_mode,    // Requested sleep depth
    input  wire        wake,          // System wakes this cycle
    output wire        stay_awake,    // Hold array, controller and clock on
    output wire        ctrl_asleep,   // Controller is asleep
    output wire        irq_req,       // Ready interrupt request, level
    output wire [7:0]  irq_vector,    // Interrupt vector offset
    output wire        irq_wake,      // Wake request to power manager
    output wire        cpu_halt,      // Stall core during code array work
    output reg         arr_start,     // Array operation start pulse
    output reg  [2:0]  arr_cmd,       // Array operation code
    output reg         arr_to_data,   // Operation targets data array
    output reg         arr_skip_data  // Whole erase leaves data array untouched
);

localparam ST_IDLE = 2'h0;
localparam ST_RUN  = 2'h1;
localparam ST_DONE = 2'h2;

reg  [2:0]  cmd;
reg         lock_app;
reg         lock_boot;
reg         boot_block;
reg         fault;
reg         irq_en;
reg         ready_flag;
reg  [15:0] wdata;
reg  [15:0] target;
reg  [2:0]  key_cnt;
reg  [1:0]  state;
reg  [15:0] op_cnt;
reg         busy_code;
reg         busy_data;
reg         asleep;
reg         was_in_boot;
reg         buf_dirty;
reg         buf_clear;
reg  [7:0]  page_buf [0:`NVMC_BUF_DEPTH-1];
reg  [15:0] next_op_cnt;
reg         op_ok;

function is_data;
    input [15:0] a;
    begin
        is_data = (a >= DATA_BASE) && (a <= DATA_END);
    end
endfunction

function is_boot;
    input [15:0] a;
    begin
        is_boot = (a >= CODE_BASE) && (a <= BOOT_END);
    end
endfunction

function is_app;
    input [15:0] a;
    begin
        is_app = (a > BOOT_END) && (a <= APP_END);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Guarded command acceptance

wire key_open  = (key_cnt != 3'h0) || dbg_access;                       // RULE7
wire cmd_wr    = reg_wr && (reg_addr == `NVMC_OFF_CMD);
wire cmd_taken = cmd_wr && key_open && (state == ST_IDLE);              // RULE8
wire [2:0] new_cmd = reg_wdata[2:0];                                     // RULE9
wire fuse_ok   = (new_cmd != `NVMC_CMD_FUSE) || dbg_access;              // RULE13
wire busy      = busy_code || busy_data;

// Cycle length of each operation; fuse and wipe are short
always @* begin
    op_ok = 1'b1;
    case (new_cmd)
        `NVMC_CMD_WIPE:   next_op_cnt = `NVMC_T_WIPE;                    // RULE11
        `NVMC_CMD_CHIP:   next_op_cnt = `NVMC_T_ARRAY;
        `NVMC_CMD_DERASE: next_op_cnt = `NVMC_T_ARRAY;
        `NVMC_CMD_FUSE:   next_op_cnt = `NVMC_T_FUSE;
        `NVMC_CMD_NONE: begin
            next_op_cnt = 16'h0001;
            op_ok = 1'b0;
        end
        default:          next_op_cnt = `NVMC_T_PAGE;                    // RULE10
    endcase
end

// Protected area: application region after lock, boot region always except from the debug port
wire prot_hit = ((new_cmd == `NVMC_CMD_PROG) || (new_cmd == `NVMC_CMD_ERASE) ||
                 (new_cmd == `NVMC_CMD_ERPROG)) &&
                ((lock_app && is_app(target)) || (!dbg_access && is_boot(target))); // RULE17

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        key_cnt <= 3'h0;
    end else if (key_written) begin
        key_cnt <= `NVMC_KEY_WINDOW;                                     // RULE7
    end else if (instr_retire && key_cnt != 3'h0) begin
        key_cnt <= key_cnt - 3'h1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        state         <= ST_IDLE;
        cmd           <= `NVMC_CMD_NONE;
        op_cnt        <= 16'h0000;
        busy_code     <= 1'b0;
        busy_data     <= 1'b0;
        fault         <= 1'b0;
        arr_start     <= 1'b0;
        arr_cmd       <= 3'h0;
        arr_to_data   <= 1'b0;
        arr_skip_data <= 1'b0;
        buf_clear     <= 1'b0;
    end else begin
        arr_start <= 1'b0;
        buf_clear <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (cmd_taken) begin
                    cmd <= new_cmd;                                      // RULE9
                    if (op_ok && fuse_ok && !prot_hit) begin
                        fault         <= 1'b0;
                        state         <= ST_RUN;
                        op_cnt        <= next_op_cnt;
                        arr_start     <= 1'b1;
                        arr_cmd       <= new_cmd;
                        arr_to_data <= is_data(target) || (new_cmd == `NVMC_CMD_DERASE); // RULE11
                        arr_skip_data <= keep_data_fuse;                 // RULE12
                        if (new_cmd == `NVMC_CMD_DERASE ||
                            (new_cmd != `NVMC_CMD_CHIP && new_cmd != `NVMC_CMD_WIPE &&
                             new_cmd != `NVMC_CMD_FUSE && is_data(target))) begin
                            busy_data <= 1'b1;                           // RULE19
                        end else begin
                            busy_code <= 1'b1;                           // RULE20
                        end
                    end else if (op_ok) begin
                        fault <= 1'b1;                                   // RULE18
                    end
                end
            end
            ST_RUN: begin
                if (op_cnt == 16'h0001) begin
                    state <= ST_DONE;
                end
                op_cnt <= op_cnt - 16'h0001;
            end
            ST_DONE: begin
                busy_code <= 1'b0;
                busy_data <= 1'b0;
                cmd       <= `NVMC_CMD_NONE;
                buf_clear <= 1'b1;                                       // RULE26
                state     <= ST_IDLE;
            end
            default: state <= ST_IDLE;
        endcase
    end
end

assign cpu_halt = busy_code;

////////////////////////////////////////////////////////////////////////////////
// Page buffer: stores AND into prior content, cleared to all ones

wire [`NVMC_BUF_AW-1:0] buf_idx = buf_addr[`NVMC_BUF_AW-1:0];
wire wipe_all = buf_clear || (wake && asleep);                           // RULE6

genvar gi;
generate
    for (gi = 0; gi < `NVMC_BUF_DEPTH; gi = gi + 1) begin : g_buf
        always @(posedge mclk or posedge rst) begin
            if (rst) begin
                page_buf[gi] <= 8'hff;                                   // RULE26
            end else if (wipe_all) begin
                page_buf[gi] <= 8'hff;
            end else if (buf_wr && !busy && buf_idx == gi) begin
                page_buf[gi] <= page_buf[gi] & buf_wdata;
            end
        end
    end
endgenerate

// Mixing sections in one buffer load is a write error flagged at store time
reg buf_in_data;
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        buf_dirty   <= 1'b0;
        buf_in_data <= 1'b0;
    end else if (wipe_all) begin
        buf_dirty <= 1'b0;
    end else if (buf_wr && !busy) begin
        buf_dirty   <= 1'b1;
        buf_in_data <= is_data(buf_addr);
    end
end

wire mix_fault = buf_wr && !busy && buf_dirty && (is_data(buf_addr) != buf_in_data);

////////////////////////////////////////////////////////////////////////////////
// Registers

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        lock_app    <= 1'b0;
        lock_boot   <= 1'b0;
        boot_block  <= 1'b0;
        was_in_boot <= 1'b0;
        irq_en      <= 1'b0;
        ready_flag  <= 1'b0;
        wdata       <= 16'h0000;
        target      <= 16'h0000;
        asleep      <= 1'b0;
    end else begin
        was_in_boot <= exec_in_boot;
        if (reg_wr && reg_addr == `NVMC_OFF_LOCK) begin
            if (reg_wdata[`NVMC_LOCK_APP]) begin
                lock_app <= 1'b1;                                        // RULE17
            end
            if (reg_wdata[`NVMC_LOCK_BOOT] && exec_in_boot) begin
                lock_boot <= 1'b1;                                       // RULE15
            end
        end
        if (lock_boot && was_in_boot && !exec_in_boot) begin
            boot_block <= 1'b1;                                          // RULE16
        end
        if (reg_wr && reg_addr == `NVMC_OFF_IRQEN) begin
            irq_en <= reg_wdata[0];
        end
        // Completion set wins over a same-cycle clear
        if (state == ST_DONE && busy_data) begin
            ready_flag <= 1'b1;                                          // RULE27
        end else if (reg_wr && reg_addr == `NVMC_OFF_IRQFLAG && reg_wdata[0]) begin
            ready_flag <= 1'b0;                                          // RULE22
        end
        if (reg_wr && reg_addr == `NVMC_OFF_DATA_L) wdata[7:0]  <= reg_wdata;
        if (reg_wr && reg_addr == `NVMC_OFF_DATA_H) wdata[15:8] <= reg_wdata; // RULE23
        if (buf_wr && !busy) begin
            target <= buf_addr;                                          // RULE25
        end else begin
            if (reg_wr && reg_addr == `NVMC_OFF_ADDR_L) target[7:0]  <= reg_wdata;
            if (reg_wr && reg_addr == `NVMC_OFF_ADDR_H) target[15:8] <= reg_wdata;
        end
        if (sleep_enter && !busy) begin
            asleep <= 1'b1;                                              // RULE3
        end else if (wake) begin
            asleep <= 1'b0;
        end
    end
end

// Sticky write error from mixed-section loads
reg mix_seen;
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        mix_seen <= 1'b0;
    end else if (mix_fault) begin
        mix_seen <= 1'b1;                                                // RULE18
    end else if (cmd_taken) begin
        mix_seen <= 1'b0;
    end
end

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
            `NVMC_OFF_CMD:     reg_rdata <= {5'h00, cmd};
            `NVMC_OFF_LOCK:    reg_rdata <= {6'h00, lock_boot, lock_app};
            `NVMC_OFF_STATUS:  reg_rdata <= {5'h00, fault | mix_seen, busy_data, busy_code};
            `NVMC_OFF_IRQEN:   reg_rdata <= {7'h00, irq_en};
            `NVMC_OFF_IRQFLAG: reg_rdata <= {7'h00, ready_flag};
            `NVMC_OFF_DATA_L:  reg_rdata <= wdata[7:0];
            `NVMC_OFF_DATA_H:  reg_rdata <= wdata[15:8];
            `NVMC_OFF_ADDR_L:  reg_rdata <= target[7:0];
            `NVMC_OFF_ADDR_H:  reg_rdata <= target[15:8];
            default:           reg_rdata <= 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read masking, interrupt and sleep outputs

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        mem_rdata <= 8'h00;
    end else if (mem_rd) begin
        mem_rdata <= (boot_block && is_boot(mem_addr)) ? 8'h00 : mem_rdata_raw; // RULE14
    end
end

assign irq_req     = irq_en && ready_flag;                               // RULE2
assign irq_vector  = `NVMC_IRQ_VECTOR;                                   // RULE1
assign irq_wake    = irq_req && asleep && (sleep_mode == `NVMC_SLEEP_IDLE); // RULE5
assign stay_awake  = busy;                                               // RULE4
assign ctrl_asleep = asleep;

endmodule // nvmc_ctrl
`default_nettype wire

// >>> nvmc_ctrl_sva.sv
// Port-level assertions for the nonvolatile memory controller.
// Bound to every nvmc_ctrl instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module nvmc_ctrl_sva (
    input wire logic       mclk,           // Clock
    input wire logic       rst,            // Reset
    input wire logic [3:0] reg_addr,       // Offset
    input wire logic       reg_wr,         // Write strobe
    input wire logic [7:0] reg_wdata,      // Write data
    input wire logic       dbg_access,     // Debug port
    input wire logic       mem_rd,         // Array read
    input wire logic [7:0] mem_rdata_raw,  // Raw data
    input wire logic [7:0] mem_rdata,      // Masked data
    input wire logic       keep_data_fuse, // Preserve fuse
    input wire logic       stay_awake,     // Busy hold
    input wire logic       ctrl_asleep,    // Asleep
    input wire logic       irq_req,        // Request
    input wire logic [7:0] irq_vector,     // Vector
    input wire logic       irq_wake,       // Wake request
    input wire logic       arr_start,      // Start pulse
    input wire logic [2:0] arr_cmd,        // Operation
    input wire logic       arr_skip_data   // Keep data array
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    vec_zero_a: assert property (irq_vector == 8'h00)
        else $error("vector offset not zero");
    start_cause_a: assert property (arr_start |-> $past(reg_wr) && $past(reg_addr) == 4'h0)
        else $error("start without command write");
    cmd_none_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h0
        |=> !arr_start) else $error("no-op command started");
    core_fuse_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h7
        && !dbg_access |=> !arr_start) else $error("core started fuse burn");
    cmd_code_a: assert property (arr_start |-> arr_cmd == $past(reg_wdata[2:0]))
        else $error("operation code differs from write");
    // Wipe takes seven counts; a short slack covers the done and clear cycles
    wipe_len_a: assert property (arr_start && arr_cmd == 3'h4
        |-> stay_awake[*7] ##[1:3] !stay_awake) else $error("wipe length wrong");
    skip_fuse_a: assert property (arr_start && arr_cmd == 3'h5
        |-> arr_skip_data == $past(keep_data_fuse)) else $error("preserve fuse ignored");
    busy_sleep_a: assert property (ctrl_asleep |-> !stay_awake)
        else $error("asleep while busy");
    wake_irq_a: assert property (irq_wake |-> irq_req)
        else $error("wake without request");
    rd_mask_a: assert property (mem_rd |=> mem_rdata == $past(mem_rdata_raw)
        || mem_rdata == 8'h00) else $error("read data neither raw nor zero");
endmodule // nvmc_ctrl_sva

bind nvmc_ctrl nvmc_ctrl_sva chk_u (.*);
`default_nettype wire

// >>> nvmc_core_model.sv
// Core-side model: register bus cycles, key write and retire pulses.
// Assumes the controller samples requests on rising mclk.
`timescale 1ns/1ps
`default_nettype none
module nvmc_core_model (
    input  wire logic       mclk,        // Clock
    input  wire logic [7:0] reg_rdata,   // Read data
    output var  logic [3:0] reg_addr,    // Offset
    output var  logic       reg_wr,      // Write strobe
    output var  logic       reg_rd,      // Read strobe
    output var  logic [7:0] reg_wdata,   // Write data
    output var  logic       dbg_access,  // Debug port access
    output var  logic       key_written, // Key pulse
    output var  logic       instr_retire // Retire pulse
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        dbg_access = 1'b0;
        key_written = 1'b0;
        instr_retire = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Released address and data lines show the inverse, so a stale value never looks live
    task automatic req(input logic [3:0] a, input logic [7:0] d, input logic w, input logic g);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        dbg_access <= g;
        @(posedge mclk);
        reg_addr <= ~a;
        reg_wdata <= ~d;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        dbg_access <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic g);
        req(a, d, 1'b1, g);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        req(a, 8'h00, 1'b0, 1'b0);
        d = reg_rdata;
    endtask
    // Key, then n retired instructions before the guarded write
    task automatic key(input int n);
        @(posedge mclk);
        key_written <= 1'b1;
        repeat (n) begin
            @(posedge mclk);
            key_written <= 1'b0;
            instr_retire <= 1'b1;
        end
        @(posedge mclk);
        key_written <= 1'b0;
        instr_retire <= 1'b0;
    endtask
endmodule // nvmc_core_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for nvmc_ctrl with the core bus model.
// Assumes default region bounds: data 0x1400, code 0x8000, boot to 0x81ff.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk, rst, exec_in_boot, buf_wr, mem_rd, keep_data_fuse, sleep_enter, wake;
    logic [15:0] buf_addr, mem_addr;
    logic [7:0]  buf_wdata, mem_rdata_raw;
    logic [1:0]  sleep_mode;
    wire  [3:0]  reg_addr;
    wire  [7:0]  reg_wdata, reg_rdata, mem_rdata, irq_vector;
    wire  [2:0]  arr_cmd;
    wire         reg_wr, reg_rd, dbg_access, key_written, instr_retire, stay_awake, ctrl_asleep;
    wire         irq_req, irq_wake, cpu_halt, arr_start, arr_to_data, arr_skip_data;
    int          miscompares, n_tests;
    nvmc_core_model core_u (.*);
    nvmc_ctrl dut_u (.*);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        core_u.rd(a, d);
        chk(d, exp, "register");
    endtask
    task automatic store(input logic [15:0] a);
        @(posedge mclk);
        buf_wr <= 1'b1;
        buf_addr <= a;
        @(posedge mclk);
        buf_wr <= 1'b0;
    endtask
    task automatic memrd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        mem_rd <= 1'b1;
        mem_addr <= a;
        @(posedge mclk);
        mem_rd <= 1'b0;
        #1;
        chk(mem_rdata, exp, "array read");
    endtask
    task automatic nap(input logic go, input logic [1:0] m);
        @(posedge mclk);
        sleep_enter <= go;
        wake <= !go;
        sleep_mode <= m;
        @(posedge mclk);
        sleep_enter <= 1'b0;
        wake <= 1'b0;
        #1;
    endtask
    task automatic wait_idle;
        logic [7:0] d;
        for (int k = 0; k < 2000; k++) begin
            core_u.rd(4'h2, d);
            if (d[1:0] === 2'b00)
                return;
        end
        miscompares++;
        $display("unexpected at %0t: busy never cleared", $time);
        end_sim;
    endtask
    task automatic cmd(input int n, input logic [7:0] c);
        core_u.key(n);
        core_u.wr(4'h0, c, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        for (int i = 0; i < 10; i++)
            if (i != 5)
                rdchk(i[3:0], 8'h00);
        chk(irq_vector, 8'h00, "vector");
        core_u.wr(4'h6, 8'ha5, 1'b0);
        core_u.wr(4'h7, 8'h5a, 1'b0);
        rdchk(4'h6, 8'ha5);
        rdchk(4'h7, 8'h5a);
        $display("t_regs done");
    endtask
    task automatic t_guard;
        core_u.wr(4'h0, 8'h04, 1'b0);
        rdchk(4'h0, 8'h00);
        cmd(5, 8'h04);
        rdchk(4'h0, 8'h00);
        cmd(3, 8'h04);
        rdchk(4'h0, 8'h04);
        repeat (12) @(posedge mclk);
        rdchk(4'h0, 8'h00);
        $display("t_guard done");
    endtask
    task automatic t_data;
        store(16'h1403);
        rdchk(4'h8, 8'h03);
        rdchk(4'h9, 8'h14);
        cmd(0, 8'h01);
        rdchk(4'h2, 8'h02);
        wait_idle;
        rdchk(4'h4, 8'h01);
        core_u.wr(4'h3, 8'h01, 1'b0);
        chk({7'h0, irq_req}, 8'h01, "irq");
        core_u.wr(4'h4, 8'h01, 1'b0);
        chk({7'h0, irq_req}, 8'h00, "irq");
        core_u.wr(4'h3, 8'h00, 1'b0);
        $display("t_data done");
    endtask
    task automatic t_code;
        store(16'h8300);
        cmd(2, 8'h02);
        rdchk(4'h2, 8'h01);
        chk({7'h0, cpu_halt}, 8'h01, "halt");
        wait_idle;
        core_u.wr(4'h1, 8'h01, 1'b0);
        core_u.wr(4'h1, 8'h00, 1'b0);
        rdchk(4'h1, 8'h01);
        store(16'h8300);
        cmd(1, 8'h01);
        rdchk(4'h2, 8'h04);
        $display("t_code done");
    endtask
    task automatic t_boot;
        core_u.wr(4'h1, 8'h02, 1'b0);
        rdchk(4'h1, 8'h01);
        @(posedge mclk) exec_in_boot <= 1'b1;
        core_u.wr(4'h1, 8'h02, 1'b0);
        rdchk(4'h1, 8'h03);
        memrd(16'h8010, 8'h5a);
        @(posedge mclk) exec_in_boot <= 1'b0;
        memrd(16'h8010, 8'h00);
        $display("t_boot done");
    endtask
    task automatic t_fuse;
        core_u.wr(4'h8, 8'h12, 1'b1);
        core_u.wr(4'h6, 8'h01, 1'b1);
        cmd(0, 8'h07);
        rdchk(4'h2, 8'h04);
        core_u.wr(4'h0, 8'h07, 1'b1);
        @(posedge mclk);
        #1;
        chk({5'h0, arr_cmd}, 8'h07, "fuse op");
        repeat (80) @(posedge mclk);
        $display("t_fuse done");
    endtask
    task automatic t_erase;
        @(posedge mclk) keep_data_fuse <= 1'b1;
        cmd(0, 8'h05);
        @(posedge mclk);
        #1;
        chk({7'h0, arr_skip_data}, 8'h01, "keep data");
        repeat (1040) @(posedge mclk);
        cmd(0, 8'h06);
        rdchk(4'h2, 8'h02);
        chk({7'h0, arr_to_data}, 8'h01, "data target");
        repeat (1040) @(posedge mclk);
        $display("t_erase done");
    endtask
    task automatic t_sleep;
        store(16'h1400);
        cmd(0, 8'h01);
        nap(1'b1, 2'h3);
        chk({6'h0, ctrl_asleep, stay_awake}, 8'h01, "busy sleep");
        wait_idle;
        core_u.wr(4'h3, 8'h01, 1'b0);
        nap(1'b1, 2'h2);
        chk({6'h0, ctrl_asleep, irq_wake}, 8'h02, "deep sleep");
        nap(1'b0, 2'h0);
        store(16'h1400);
        nap(1'b1, 2'h1);
        chk({6'h0, ctrl_asleep, irq_wake}, 8'h03, "idle sleep");
        nap(1'b0, 2'h0);
        chk({7'h0, ctrl_asleep}, 8'h00, "awake");
        store(16'h8300);
        rdchk(4'h2, 8'h00);
        $display("t_sleep done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {exec_in_boot, buf_wr, mem_rd, keep_data_fuse, sleep_enter, wake} = 6'h00;
        buf_addr = 16'h0000;
        mem_addr = 16'h0000;
        buf_wdata = 8'h3c;
        mem_rdata_raw = 8'h5a;
        sleep_mode = 2'h0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_guard;
        t_data;
        t_code;
        t_boot;
        t_fuse;
        t_erase;
        t_sleep;
        end_sim;
    end
endmodule // tb
`default_nettype wire
